// [hdl/ast_tx_top.sv]
// Transmit half of an asynchronous serial port with an APB register slave.
// Assumes a baud generator on ref_clk that takes baud_cfg and returns one
// baud_tick pulse per bit period, and a pad that obeys tx_pin_oe.
// Behaviour
// - Send only with transmitter on, async, port on.
// - Port on drives transmit pin as output.
// - Room flag sets once transmitter turns on.
// - Holding write starts send, moves if idle.
// - New character waits while shifter busy.
// - Pending move within one instruction cycle.
// - Invert bit flips idle and data levels.
// - Inversion applies in asynchronous operation only.
// - Room flag set when enabled, holding empty.
// - Room flag valid by second instruction cycle.
// - Room flag is read only.
// - Room flag independent of transmit interrupt enable.
// - Interrupt request when all three enables set.
// - Shifter empty clears on load until sent.
// - Shifter empty raises no interrupt.
// - Nine-bit mode sends ninth bit as MSB.
// - All nine bits captured together at write.
// - Frame is start, data, stop, one period each.
// - Data bits go least significant first.
// - Line rests at mark when idle.
// - Bit timing from external 8/16-bit divisor generator.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module ast_tx_top
    import ast_pkg::*;
#(
    parameter int CYCLE_CLOCKS = CYCLE_DIV
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              baud_tick,
    output ast_baud_cfg_type       baud_cfg,
    output logic                   baud_restart,
    output logic                   tx_pin_out,
    output logic                   tx_pin_oe,
    output logic                   irq_request
);
    logic [7:0]   txs_q;
    logic [7:0]   rxs_q;
    logic [7:0]   bdc_q;
    logic [7:0]   div_low_q;
    logic [7:0]   div_high_q;
    logic [2:0]   ien_q;
    ast_char_type hold_q;
    logic         hold_full_q;
    logic         hold_full_d;
    logic         room_q;
    logic         irq_q;
    logic [31:0]  prdata_q;
    logic [31:0]  rd_data;
    logic         pready_q;
    logic         pslverr_q;
    logic         pin_q;
    logic         oe_q;
    logic         restart_q;
    ast_baud_cfg_type baud_cfg_q;
    logic         tcy_tick;
    logic         line;
    logic         busy;

    // APB decode. The slave answers in the first access cycle.
    wire setup     = psel && !penable;
    wire wr        = psel && penable && pready_q && pwrite;
    wire hit_txs   = (paddr == OFS_TX_STATUS_CTL);
    wire hit_rxs   = (paddr == OFS_RX_STATUS_CTL);
    wire hit_bdc   = (paddr == OFS_BAUD_CONTROL);
    wire hit_dlow  = (paddr == OFS_BAUD_DIV_LOW);
    wire hit_dhigh = (paddr == OFS_BAUD_DIV_HIGH);
    wire hit_hold  = (paddr == OFS_TX_HOLDING);
    wire hit_ien   = (paddr == OFS_IRQ_ENABLES);
    wire hit_flags = (paddr == OFS_IRQ_FLAGS);
    wire hit_any   = hit_txs || hit_rxs || hit_bdc || hit_dlow ||
                     hit_dhigh || hit_hold || hit_ien || hit_flags;
    wire wr_hold   = wr && hit_hold;

    wire port_on      = rxs_q[RXS_PORT_ON];
    wire sync_mode    = txs_q[TXS_SYNC];
    wire tx_enabled   = txs_q[TXS_TX_ON] && !sync_mode && port_on;
    wire invert       = bdc_q[BDC_INVERT] && !sync_mode;
    wire shifter_empty = !busy;

    // A character moves only on an instruction-cycle boundary.
    wire load = hold_full_q && !busy && tcy_tick && tx_enabled;

    wire [7:0] txs_rd   = {txs_q[7:2], shifter_empty, txs_q[TXS_NINTH]};
    wire [7:0] flags_rd = {7'h00, room_q};

    always_comb begin
        if (hit_txs) begin
            rd_data = {24'h000000, txs_rd};
        end else if (hit_rxs) begin
            rd_data = {24'h000000, rxs_q};
        end else if (hit_bdc) begin
            rd_data = {24'h000000, bdc_q};
        end else if (hit_dlow) begin
            rd_data = {24'h000000, div_low_q};
        end else if (hit_dhigh) begin
            rd_data = {24'h000000, div_high_q};
        end else if (hit_hold) begin
            rd_data = {23'h000000, hold_q};
        end else if (hit_ien) begin
            rd_data = {29'h00000000, ien_q};
        end else if (hit_flags) begin
            rd_data = {24'h000000, flags_rd};
        end else begin
            rd_data = 32'h00000000;
        end
    end

    // A write in the cycle of a move still lands: the move takes the old
    // character and the new one refills the holding register.
    always_comb begin
        if (!tx_enabled) begin
            hold_full_d = 1'b0;
        end else if (wr_hold) begin
            hold_full_d = 1'b1;
        end else if (load) begin
            hold_full_d = 1'b0;
        end else begin
            hold_full_d = hold_full_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit_any;
            prdata_q  <= setup ? rd_data : prdata_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            txs_q      <= REG_RESET;
            rxs_q      <= REG_RESET;
            bdc_q      <= REG_RESET;
            div_low_q  <= REG_RESET;
            div_high_q <= REG_RESET;
            ien_q      <= 3'h0;
        end else if (wr) begin
            if (hit_txs) begin
                txs_q <= pwdata[7:0] & TXS_WRITE_MASK;
            end
            if (hit_rxs) begin
                rxs_q <= pwdata[7:0] & RXS_WRITE_MASK;
            end
            if (hit_bdc) begin
                bdc_q <= pwdata[7:0] & BDC_WRITE_MASK;
            end
            if (hit_dlow) begin
                div_low_q <= pwdata[7:0];
            end
            if (hit_dhigh) begin
                div_high_q <= pwdata[7:0];
            end
            if (hit_ien) begin
                ien_q <= pwdata[2:0] & IEN_WRITE_MASK[2:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            hold_q      <= '0;
            hold_full_q <= 1'b0;
        end else begin
            if (wr_hold && tx_enabled) begin
                hold_q <= {txs_q[TXS_NINTH], pwdata[7:0]};
            end
            hold_full_q <= hold_full_d;
        end
    end

    // The flag follows the holding register only on instruction-cycle
    // edges, so a read right after a write may still see the old value.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            room_q <= 1'b0;
        end else if (tcy_tick) begin
            room_q <= tx_enabled && !hold_full_q;
        end
    end

    // Only the room flag reaches the request; shifter empty is polled.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= room_q && (ien_q == IEN_ALL_ON);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pin_q      <= 1'b1;
            oe_q       <= 1'b0;
            restart_q  <= 1'b0;
            baud_cfg_q <= '0;
        end else begin
            pin_q      <= (tx_enabled ? line : 1'b1) ^ invert;
            oe_q       <= port_on;
            restart_q  <= load;
            baud_cfg_q <= {div_high_q, div_low_q, txs_q[TXS_HIGH_SPEED],
                           bdc_q[BDC_WIDE]};
        end
    end

    ast_cycle_div #(
        .DIV (CYCLE_CLOCKS)
    ) u_cycle_div (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .tick    (tcy_tick)
    );

    ast_shifter u_shifter (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clear     (!tx_enabled),
        .load      (load),
        .nine_bit  (txs_q[TXS_NINE_BIT]),
        .data      (hold_q),
        .baud_tick (baud_tick),
        .line      (line),
        .busy      (busy)
    );

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign baud_cfg     = baud_cfg_q;
    assign baud_restart = restart_q;
    assign tx_pin_out   = pin_q;
    assign tx_pin_oe    = oe_q;
    assign irq_request  = irq_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_load_taken;
        load ##1 !shifter_empty;
    endsequence

    sequence s_still_busy;
        !shifter_empty ##1 !shifter_empty;
    endsequence

    a_pin_drive: assert property (
        $rose(port_on) |=> tx_pin_oe)
        else $error("transmit pin not driven after port on");
    a_room_enable: assert property (
        $rose(tx_enabled) && !hold_full_q |-> ##[1:8] room_q)
        else $error("room flag not set after transmitter on");
    a_room_state: assert property (
        tcy_tick |=> room_q == $past(tx_enabled && !hold_full_q))
        else $error("room flag disagrees with holding state");
    a_room_ro: assert property (
        wr && hit_flags && !tcy_tick |=> $stable(room_q))
        else $error("software write changed the room flag");
    a_hold_wait: assert property (
        hold_full_q && busy && tx_enabled ##1 tx_enabled |-> hold_full_q)
        else $error("pending character left while shifter busy");
    a_move_tcy: assert property (
        hold_full_q && !busy && tx_enabled |-> ##[1:4] (busy || !tx_enabled))
        else $error("pending character not moved in one cycle");
    a_irq_gate: assert property (
        irq_request |-> $past(room_q) && $past(ien_q) == IEN_ALL_ON)
        else $error("interrupt request without all enables");
    a_empty_clear: assert property (
        s_load_taken |-> s_still_busy)
        else $error("shifter empty not cleared after move");
    a_idle_level: assert property (
        (!busy && tx_enabled)[*2] |-> tx_pin_out == !$past(invert))
        else $error("idle level does not follow invert bit");
endmodule : ast_tx_top

// [inc/ast_pkg.sv]
// Register map, field positions and carriers of the serial transmitter.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package ast_pkg;
    localparam int         ADDR_W            = 8;
    localparam logic [7:0] OFS_TX_STATUS_CTL = 8'h00;
    localparam logic [7:0] OFS_RX_STATUS_CTL = 8'h04;
    localparam logic [7:0] OFS_BAUD_CONTROL  = 8'h08;
    localparam logic [7:0] OFS_BAUD_DIV_LOW  = 8'h0C;
    localparam logic [7:0] OFS_BAUD_DIV_HIGH = 8'h10;
    localparam logic [7:0] OFS_TX_HOLDING    = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLES   = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h1C;

    localparam int TXS_NINE_BIT   = 6;
    localparam int TXS_TX_ON      = 5;
    localparam int TXS_SYNC       = 4;
    localparam int TXS_HIGH_SPEED = 2;
    localparam int TXS_EMPTY      = 1;
    localparam int TXS_NINTH      = 0;
    localparam int RXS_PORT_ON    = 7;
    localparam int BDC_INVERT     = 4;
    localparam int BDC_WIDE       = 3;
    localparam int IEN_GLOBAL     = 2;
    localparam int IEN_PERIPHERAL = 1;
    localparam int IEN_TRANSMIT   = 0;
    localparam int FLG_ROOM       = 0;

    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [7:0] TXS_WRITE_MASK = 8'hFD;
    localparam logic [7:0] RXS_WRITE_MASK = 8'hF8;
    localparam logic [7:0] BDC_WRITE_MASK = 8'h1B;
    localparam logic [7:0] IEN_WRITE_MASK = 8'h07;
    localparam logic [2:0] IEN_ALL_ON     = 3'h7;

    localparam int         CYCLE_DIV    = 4;
    localparam logic [3:0] FRAME_BITS_8 = 4'hA;
    localparam logic [3:0] FRAME_BITS_9 = 4'hB;

    typedef struct packed {
        logic       ninth;
        logic [7:0] low;
    } ast_char_type;

    typedef struct packed {
        logic [15:0] divisor;
        logic        high_speed;
        logic        wide;
    } ast_baud_cfg_type;
endpackage : ast_pkg

// [hdl/ast_cycle_div.sv]
// Instruction-cycle enable divider for the serial transmitter.
// Assumes a free-running ref_clk; tick is a one-cycle pulse.
`timescale 1ns/1ps
module ast_cycle_div
    import ast_pkg::*;
#(
    parameter int DIV = CYCLE_DIV
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    output logic      tick
);
    localparam int         W    = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_q;
    wire          at_last = (cnt_q == LAST);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= at_last ? '0 : cnt_q + 1'b1;
            tick  <= at_last;
        end
    end
endmodule : ast_cycle_div

// [hdl/ast_shifter.sv]
// Frame shifter: start bit, eight or nine data bits, one stop bit.
// Assumes one-cycle baud_tick pulses on ref_clk, one per bit period.
`timescale 1ns/1ps
module ast_shifter
    import ast_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          clear,
    input  wire logic          load,
    input  wire logic          nine_bit,
    input  wire ast_char_type  data,
    input  wire logic          baud_tick,
    output logic               line,
    output logic               busy
);
    logic [10:0] sr_q;
    logic [3:0]  cnt_q;

    wire [10:0] frame_8 = {2'b11, data.low, 1'b0};
    wire [10:0] frame_9 = {1'b1, data, 1'b0};
    wire [10:0] frame   = nine_bit ? frame_9 : frame_8;

    always_ff @(posedge ref_clk) begin
        if (!reset_n || clear) begin
            sr_q  <= 11'h7FF;
            cnt_q <= 4'h0;
        end else if (load) begin
            sr_q  <= frame;
            cnt_q <= nine_bit ? FRAME_BITS_9 : FRAME_BITS_8;
        end else if (baud_tick && cnt_q != 4'h0) begin
            sr_q  <= {1'b1, sr_q[10:1]};
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign line = sr_q[0];
    assign busy = (cnt_q != 4'h0);

    a_start_space: assert property (@(posedge ref_clk) disable iff (!reset_n)
        load && !clear |=> !line && busy)
        else $error("start bit not at space level after load");
    a_lsb_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
        load && !clear |=> sr_q[1] == $past(data.low[0]))
        else $error("first data bit is not the least significant");
endmodule : ast_shifter

// [verif/ast_rx_model.sv]
// Remote receiver model listening on the transmit line.
// Assumes BP equals the bench baud period in ref_clk cycles.
`timescale 1ns/1ps
module ast_rx_model #(
    parameter int BP = 16
) (
    input wire logic ref_clk,
    input wire logic invert,
    input wire logic nine,
    input wire logic line
);
    logic [8:0] got[$];
    logic [8:0] sh;
    logic       prev = 1'b1;
    logic       busy = 1'b0;
    int         cnt;
    int         idx;
    wire        lvl = line ^ invert;

    // Sampling mid-bit absorbs the one-cycle skew of the baud restart.
    always @(posedge ref_clk) begin
        if (!busy && prev && !lvl) begin
            busy = 1'b1;
            cnt = 0;
            idx = 0;
            sh = '0;
        end else if (busy) begin
            cnt++;
            if (cnt == BP / 2 + idx * BP) begin
                if (idx > 0 && idx <= (nine ? 9 : 8)) begin
                    sh[idx-1] = lvl;
                end
                if (idx == (nine ? 10 : 9)) begin
                    busy = 1'b0;
                    if (lvl) begin
                        got.push_back(sh);
                    end
                end
                idx++;
            end
        end
        prev = lvl;
    end
endmodule : ast_rx_model

// [verif/ast_tx_top_tb.sv]
// Self-checking bench for the serial transmitter and its APB registers.
// Assumes the bench acts as APB master and as the baud generator.
`timescale 1ns/1ps
module ast_tx_top_tb
    import ast_pkg::*;
;
    localparam int BP = 16;
    typedef struct packed {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [8:0] x;
        logic       e;
    } ast_row_type;
    ast_row_type rows [13] = '{
        '{1'b0, 8'h00, 8'h00, 9'h002, 1'b0}, '{1'b0, 8'h04, 8'h00, 9'h000, 1'b0},
        '{1'b0, 8'h08, 8'h00, 9'h000, 1'b0}, '{1'b0, 8'h1C, 8'h00, 9'h000, 1'b0},
        '{1'b1, 8'h0C, 8'hA5, 9'h0A5, 1'b0}, '{1'b1, 8'h10, 8'h3C, 9'h03C, 1'b0},
        '{1'b1, 8'h08, 8'hFF, 9'h01B, 1'b0}, '{1'b1, 8'h04, 8'h7F, 9'h078, 1'b0},
        '{1'b1, 8'h00, 8'h9D, 9'h09F, 1'b0}, '{1'b1, 8'h1C, 8'hFF, 9'h000, 1'b0},
        '{1'b1, 8'h18, 8'h03, 9'h003, 1'b0}, '{1'b0, 8'h20, 8'h00, 9'h000, 1'b1},
        '{1'b1, 8'h14, 8'h5A, 9'h000, 1'b0}};
    logic              ref_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              baud_tick = 1'b0;
    ast_baud_cfg_type  baud_cfg;
    logic              baud_restart;
    logic              tx_pin_out;
    logic              tx_pin_oe;
    logic              irq_request;
    logic              inv = 1'b0;
    logic              nine = 1'b0;
    logic [31:0]       rdat;
    logic              rerr;
    int                bcnt = 0;
    int                cyc = 0;
    int                bad_count = 0;
    int                checks = 0;

    ast_tx_top #(.CYCLE_CLOCKS(4)) ast_tx_top_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .baud_tick(baud_tick), .baud_cfg(baud_cfg),
        .baud_restart(baud_restart), .tx_pin_out(tx_pin_out),
        .tx_pin_oe(tx_pin_oe), .irq_request(irq_request));
    ast_rx_model #(.BP(BP)) ast_rx_model_i (.ref_clk(ref_clk), .invert(inv),
        .nine(nine), .line(tx_pin_out));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Restarting on the design's pulse keeps the start bit a full period.
    always @(posedge ref_clk) begin
        bcnt <= (baud_restart === 1'b1 || bcnt == BP - 1) ? 0 : bcnt + 1;
        baud_tick <= (bcnt == BP - 2) && (baud_restart !== 1'b1);
    end

    // The whole run needs under two thousand cycles; the ceiling leaves margin.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), x, rdat);
    endtask : rd

    task automatic rx_wait(input int n);
        int k;
        k = 0;
        while (ast_rx_model_i.got.size() < n && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
    endtask : rx_wait

    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                apb(1'b1, rows[i].a, {24'h0, rows[i].d});
            end
            rd(rows[i].a, {23'h0, rows[i].x});
            chk("pslverr", {31'h0, rows[i].e}, {31'h0, rerr});
        end
        chk("baud_cfg", 32'hF297, {14'h0, baud_cfg});
        $display("register table test done");
        apb(1'b1, OFS_BAUD_CONTROL, 32'h0);
        apb(1'b1, OFS_RX_STATUS_CTL, 32'h80);
        apb(1'b1, OFS_TX_STATUS_CTL, 32'h20);
        repeat (12) @(posedge ref_clk);
        chk("oe", 32'h1, {31'h0, tx_pin_oe});
        rd(OFS_IRQ_FLAGS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq_request});
        apb(1'b1, OFS_IRQ_ENABLES, 32'h7);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'h1, {31'h0, irq_request});
        apb(1'b1, OFS_IRQ_ENABLES, 32'h6);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'h0, {31'h0, irq_request});
        rd(OFS_IRQ_FLAGS, 32'h1);
        $display("enable test done");
        repeat (BP * 12) @(posedge ref_clk);
        ast_rx_model_i.got.delete();
        apb(1'b1, OFS_TX_HOLDING, 32'h55);
        repeat (12) @(posedge ref_clk);
        rd(OFS_TX_STATUS_CTL, 32'h20);
        apb(1'b1, OFS_TX_HOLDING, 32'hC3);
        repeat (12) @(posedge ref_clk);
        rd(OFS_IRQ_FLAGS, 32'h0);
        rx_wait(2);
        chk("frame", 32'h55, {23'h0, ast_rx_model_i.got.pop_front()});
        chk("frame", 32'hC3, {23'h0, ast_rx_model_i.got.pop_front()});
        repeat (BP + 8) @(posedge ref_clk);
        rd(OFS_TX_STATUS_CTL, 32'h22);
        rd(OFS_IRQ_FLAGS, 32'h1);
        $display("back to back test done");
        apb(1'b1, OFS_BAUD_CONTROL, 32'h10);
        // The pin flips one edge after the write; the model follows then.
        @(posedge ref_clk);
        inv <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("idle", 32'h0, {31'h0, tx_pin_out});
        nine <= 1'b1;
        apb(1'b1, OFS_TX_STATUS_CTL, 32'h61);
        apb(1'b1, OFS_TX_HOLDING, 32'h3A);
        rd(OFS_TX_HOLDING, 32'h13A);
        rx_wait(1);
        chk("frame9", 32'h13A, {23'h0, ast_rx_model_i.got.pop_front()});
        $display("nine bit test done");
        apb(1'b1, OFS_TX_HOLDING, 32'hFF);
        repeat (BP * 3) @(posedge ref_clk);
        apb(1'b1, OFS_TX_STATUS_CTL, 32'h0);
        repeat (8) @(posedge ref_clk);
        chk("abort", 32'h0, {31'h0, tx_pin_out});
        rd(OFS_TX_STATUS_CTL, 32'h02);
        rd(OFS_IRQ_FLAGS, 32'h0);
        apb(1'b1, OFS_TX_STATUS_CTL, 32'h30);
        apb(1'b1, OFS_TX_HOLDING, 32'h55);
        repeat (BP * 2) @(posedge ref_clk);
        rd(OFS_TX_STATUS_CTL, 32'h32);
        apb(1'b1, OFS_RX_STATUS_CTL, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("oe", 32'h0, {31'h0, tx_pin_oe});
        $display("abort test done");
        conclude();
    end
endmodule : ast_tx_top_tb
